/* File: src/thermal_throttle_pin_timer_alert.sv */
// Thermal throttle pin: assertion timer, limit alert, pin drive and speed sync
// Notes on behaviour
// R1: Eight-bit limit register for the cumulative assertion timer, up to 5.825 s.
// R2: Timer above limit sets status two bit 5 and pulls the alert low.
// R3: Mask two bit 5 blocks the alert only; the status flag still sets.
// R4: Limit zero alerts on the very first pin assertion.
// R5: Limit one alerts once accumulated assertion passes 45.52 ms.
// R6: Config three bit 1 enables timer monitoring; off after reset.
// R7: Pin function field routes timer and output to the pin, needs enable.
// R8: Full-duty bit forces fans to full while pin low, only if running.
// R9: Pin driven low once a temperature exceeds its critical limit by 0.25 C.
// R10: Pin stays low while above limit, released at or below it.
// R11: Three critical limits at consecutive offsets for remote one, local, remote two.
// R12: Channel config bit 3 lets that channel assert the pin.
// R13: Limit at -64 C offset-64 or -128 C two's complement disables channel.
// R14: Speed one syncs to drive one; speeds three and four to drive three.
// R15: Sync bit set maps speeds two, three and four to drive three.
// R16: No sync needed in high-frequency mode with four-wire fans.
// R17: Drive frequency selectable among low options or one high option.
// R18: First assertion sets timer bit 0; after 45.52 ms bit 0 is the 22.76 ms LSB.
// R19: Timer accumulates over assertions, saturates, and clears when read.
// R20: Flags stay set until condition gone and status read; alert held meanwhile.
// R21: Sync bit clear maps speed two to drive two.
module thermal_throttle_pin_timer_alert
	import thermal_throttle_pin_pkg::*;
#(
	parameter int STEP_CYCLES = TIMER_STEP_CYCLES
)
(
	input  wire logic  ref_clk,
	input  wire logic  rst_b,
	input  wire logic  [7:0] reg_addr,
	input  wire logic  [7:0] reg_wdata,
	input  wire logic  reg_wr,
	input  wire logic  reg_rd,
	output logic       [7:0] reg_rdata,
	input  wire logic  thermal_throttle_pin_in,
	output logic       thermal_throttle_pin_out,
	output logic       thermal_throttle_pin_oe,
	output logic       smbalert_b,
	input  wire temp_set_t temps,
	input  wire logic  offset64_mode,
	input  wire logic  fans_running,
	input  wire logic  four_wire_fans,
	output logic       full_duty_override,
	output logic       fourth_speed_input,
	output sync_map_t  tach_sync,
	output logic       tach_sync_needed,
	output logic       [2:0] pwm_freq_sel,
	output logic       pwm_high_freq
);
	localparam int PW = $clog2(STEP_CYCLES + 1);

	logic [NREGS-1:0][7:0] regs_ff;
	logic [7:0]            rdata_ff;
	logic [7:0]            timer_ff;
	logic                  half_ff;
	logic [PW-1:0]         prescale_ff;
	logic                  flag_ff;
	logic                  alert_b_ff;
	logic [2:0]            hot_ff;
	logic                  pin_oe_ff;
	logic                  full_duty_ff;
	logic                  speed4_ff;
	sync_map_t             sync_ff;
	logic                  sync_needed_ff;
	logic                  pwm_high_ff;
	logic                  pin_level;

	logic [NREGS-1:0]      wr_hit;
	logic [7:0]            reg_mux;
	logic [2:0]            armed;
	logic [2:0]            over;
	logic [2:0]            nxt_hot;
	logic [7:0]            nxt_timer;

	// Pin samples come from outside the clock domain
	pin_sync i_pin_sync (
		.ref_clk   (ref_clk),
		.rst_b     (rst_b),
		.pin_in    (thermal_throttle_pin_in),
		.pin_level (pin_level)
	);

	// Function select and decode
	wire [1:0] pin_fn       = regs_ff[IX_CFG_FOUR][1:0];
	wire       timer_en     = regs_ff[IX_CFG_THREE][BIT_TIMER_EN];
	wire       thermal_throttle_pin_fn     = timer_en && (pin_fn == PINFN_THERMAL); // see R6 see R7
	wire       thermal_throttle_pin_active = thermal_throttle_pin_fn && !pin_level;
	wire       rd_timer     = reg_rd && (reg_addr == OFS_TIMER);
	wire       rd_status    = reg_rd && (reg_addr == OFS_STATUS_TWO);
	wire       step_tick    = thermal_throttle_pin_active && (prescale_ff == PW'(STEP_CYCLES - 1));
	wire [7:0] t_limit      = regs_ff[IX_TLIMIT]; // see R1
	wire       exceed       = thermal_throttle_pin_fn && (timer_ff > t_limit); // see R2 see R4 see R5
	wire       nxt_flag     = exceed || (flag_ff && !rd_status); // see R20
	wire       mask_limit   = regs_ff[IX_MASK_TWO][BIT_LIMIT_FLAG];
	wire       nxt_alert_b  = !(nxt_flag && !mask_limit); // see R3
	wire       sync_bit     = regs_ff[IX_ACOUSTICS][BIT_SYNC];
	wire       high_sel     = (regs_ff[IX_PWM_FREQ][2:0] == PWM_FREQ_HIGH); // see R17

	// Write strobes, one per register offset
	genvar gi;
	for (gi = 0; gi < NREGS; gi++)
	begin : g_wr
		assign wr_hit[gi] = reg_wr && (reg_addr == REG_OFS[gi]);
	end

	// Read selection; unmapped offsets read as zero
	always_comb
	begin
		reg_mux = 8'h00;
		for (int i = 0; i < NREGS; i++)
			if (reg_addr == REG_OFS[i])
				reg_mux = regs_ff[i];
		if (reg_addr == OFS_TIMER)
			reg_mux = timer_ff;
		if (reg_addr == OFS_STATUS_TWO)
			reg_mux = {2'h0, flag_ff, 5'h00};
	end

	// Register file and read data
	always_ff @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			regs_ff  <= REG_RST;
			rdata_ff <= 8'h00;
		end
		else
		begin
			for (int i = 0; i < NREGS; i++)
				if (wr_hit[i])
					regs_ff[i] <= reg_wdata; // see R11
			if (reg_rd)
				rdata_ff <= reg_mux;
		end
	end

	// Next timer value: a read restarts it, an assertion underway re-marks bit 0.
	// One step is absorbed at value 1 so that bit 1 first sets at two steps.
	always_comb
	begin
		nxt_timer = timer_ff;
		if (rd_timer)
			nxt_timer = thermal_throttle_pin_active ? 8'h01 : 8'h00; // see R19
		else if (thermal_throttle_pin_active && timer_ff == 8'h00)
			nxt_timer = 8'h01; // see R18
		else if (step_tick && half_ff && timer_ff != 8'hff)
			nxt_timer = timer_ff + 8'h01; // see R18 see R19
	end

	// Accumulating assertion timer with step prescaler
	always_ff @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			timer_ff    <= 8'h00;
			half_ff     <= 1'b0;
			prescale_ff <= '0;
		end
		else
		begin
			timer_ff <= nxt_timer;
			if (rd_timer)
			begin
				half_ff     <= 1'b0;
				prescale_ff <= '0;
			end
			else if (thermal_throttle_pin_active)
			begin
				prescale_ff <= step_tick ? '0 : prescale_ff + PW'(1);
				if (step_tick)
					half_ff <= 1'b1;
			end
		end
	end

	// Sticky limit flag and alert; a new event wins over the status read
	always_ff @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			flag_ff    <= 1'b0;
			alert_b_ff <= 1'b1;
		end
		else
		begin
			flag_ff    <= nxt_flag; // see R2 see R20
			alert_b_ff <= nxt_alert_b; // see R3
		end
	end

	// Per-channel over-limit compare. Quarter-degree bits make "exceeds by 0.25"
	// a plain greater-than; two's complement flips the sign bit to compare unsigned.
	for (gi = 0; gi < 3; gi++)
	begin : g_chan
		wire [7:0] lim   = regs_ff[IX_CRIT + gi];
		wire       dis   = offset64_mode ? (lim == DIS_OFFSET64) : (lim == DIS_TWOS);
		wire [9:0] t_raw = temps.reading[gi];
		wire [9:0] t_key = offset64_mode ? t_raw : {~t_raw[9], t_raw[8:0]};
		wire [9:0] l_key = offset64_mode ? {lim, 2'h0} : {~lim[7], lim[6:0], 2'h0};
		assign armed[gi]   = regs_ff[IX_CFG + gi][BIT_THERMAL_THROTTLE_PIN_OUT_EN] && !dis; // see R12 see R13
		assign over[gi]    = t_key > l_key; // see R9
		assign nxt_hot[gi] = !armed[gi] ? 1'b0 :
			(temps.done[gi] ? over[gi] : hot_ff[gi]); // see R10
	end

	// Pin drive, full-duty override and shared-pin speed input
	always_ff @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			hot_ff       <= 3'h0;
			pin_oe_ff    <= 1'b0;
			full_duty_ff <= 1'b0;
			speed4_ff    <= 1'b1;
		end
		else
		begin
			hot_ff       <= nxt_hot;
			pin_oe_ff    <= thermal_throttle_pin_fn && (|nxt_hot); // see R9 see R10
			full_duty_ff <= thermal_throttle_pin_active && fans_running &&
				regs_ff[IX_CFG_THREE][BIT_FULL_DUTY]; // see R8
			speed4_ff    <= (pin_fn == PINFN_SPEED) ? pin_level : 1'b1; // see R7
		end
	end

	// Speed input synchronisation map
	always_ff @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			sync_ff        <= '{speed1: DRIVE_ONE, speed2: DRIVE_TWO,
				speed3: DRIVE_THREE, speed4: DRIVE_THREE};
			sync_needed_ff <= 1'b1;
			pwm_high_ff    <= 1'b0;
		end
		else
		begin
			sync_ff.speed1 <= DRIVE_ONE; // see R14
			sync_ff.speed2 <= sync_bit ? DRIVE_THREE : DRIVE_TWO; // see R15 see R21
			sync_ff.speed3 <= DRIVE_THREE; // see R14
			sync_ff.speed4 <= DRIVE_THREE; // see R14
			pwm_high_ff    <= high_sel; // see R17
			sync_needed_ff <= !(high_sel && four_wire_fans); // see R16
		end
	end

	// Outputs straight from flip-flops, pin out tied low; pin is open drain so only low is driven
	assign reg_rdata                = rdata_ff;
	assign thermal_throttle_pin_out = 1'b0;
	assign thermal_throttle_pin_oe  = pin_oe_ff;
	assign smbalert_b               = alert_b_ff;
	assign full_duty_override       = full_duty_ff;
	assign fourth_speed_input       = speed4_ff;
	assign tach_sync                = sync_ff;
	assign tach_sync_needed         = sync_needed_ff;
	assign pwm_freq_sel             = regs_ff[IX_PWM_FREQ][2:0]; // see R17
	assign pwm_high_freq            = pwm_high_ff; // see R17

	// Checks that tie outputs and state to their causes
	flag_set_a: assert property ( // see R2
		@(posedge ref_clk) disable iff (!rst_b)
		exceed |=> flag_ff)
		else $error("limit flag did not set");

	alert_path_a: assert property ( // see R2
		@(posedge ref_clk) disable iff (!rst_b)
		(exceed && !mask_limit) |=> !smbalert_b)
		else $error("alert not raised on limit");

	alert_mask_a: assert property ( // see R3
		@(posedge ref_clk) disable iff (!rst_b)
		mask_limit |=> smbalert_b)
		else $error("masked alert asserted");

	first_step_a: assert property ( // see R18
		@(posedge ref_clk) disable iff (!rst_b)
		(thermal_throttle_pin_active && timer_ff == 8'h00) |=> timer_ff == 8'h01)
		else $error("timer bit 0 not set on first assertion");

	timer_hold_a: assert property ( // see R19
		@(posedge ref_clk) disable iff (!rst_b)
		(!rd_timer && !thermal_throttle_pin_active) |=> $stable(timer_ff))
		else $error("timer moved while pin idle");

	read_clear_a: assert property ( // see R19
		@(posedge ref_clk) disable iff (!rst_b)
		(rd_timer && !thermal_throttle_pin_active) |=> timer_ff == 8'h00 && rdata_ff == $past(timer_ff))
		else $error("timer read did not clear");

	flag_sticky_a: assert property ( // see R20
		@(posedge ref_clk) disable iff (!rst_b)
		(flag_ff && !rd_status) |=> flag_ff)
		else $error("limit flag dropped without read");

	pin_hold_a: assert property ( // see R10
		@(posedge ref_clk) disable iff (!rst_b)
		(hot_ff[0] && armed[0] && !temps.done[0]) |=> hot_ff[0])
		else $error("hot state dropped between cycles");

	chan_off_a: assert property ( // see R13
		@(posedge ref_clk) disable iff (!rst_b)
		!armed[1] |=> !hot_ff[1])
		else $error("disabled channel is hot");

	pin_drive_a: assert property ( // see R9
		@(posedge ref_clk) disable iff (!rst_b)
		(thermal_throttle_pin_fn && armed[2] && temps.done[2] && over[2]) |=> thermal_throttle_pin_oe)
		else $error("pin not driven on over limit");

	sync_map_a: assert property ( // see R15
		@(posedge ref_clk) disable iff (!rst_b)
		sync_bit |=> tach_sync.speed2 == DRIVE_THREE)
		else $error("speed two not on drive three");

	full_duty_a: assert property ( // see R8
		@(posedge ref_clk) disable iff (!rst_b)
		full_duty_override |-> $past(fans_running) && $past(thermal_throttle_pin_active) &&
			$past(regs_ff[IX_CFG_THREE][BIT_FULL_DUTY]))
		else $error("full duty without running fans");
endmodule // thermal_throttle_pin_timer_alert

/* File: src/thermal_throttle_pin_pkg.sv */
// Constants, register map and carrier types of the thermal pin block
package thermal_throttle_pin_pkg;
	// Clock and timer timing
	localparam int CLK_PERIOD_NS     = 100;
	localparam int TIMER_STEP_US     = 22760; // 22.76 ms per timer step
	localparam int TIMER_STEP_CYCLES = (TIMER_STEP_US * 1000) / CLK_PERIOD_NS;

	// Register offsets
	localparam logic [7:0] OFS_R1_CFG     = 8'h5f;
	localparam logic [7:0] OFS_LOC_CFG    = 8'h60;
	localparam logic [7:0] OFS_R2_CFG     = 8'h61;
	localparam logic [7:0] OFS_ACOUSTICS  = 8'h62;
	localparam logic [7:0] OFS_R1_CRIT    = 8'h6a;
	localparam logic [7:0] OFS_LOC_CRIT   = 8'h6b;
	localparam logic [7:0] OFS_R2_CRIT    = 8'h6c;
	localparam logic [7:0] OFS_MASK_TWO   = 8'h75;
	localparam logic [7:0] OFS_CFG_THREE  = 8'h78;
	localparam logic [7:0] OFS_TLIMIT     = 8'h7a;
	localparam logic [7:0] OFS_PWM_FREQ   = 8'h7c;
	localparam logic [7:0] OFS_CFG_FOUR   = 8'h7d;
	localparam logic [7:0] OFS_STATUS_TWO = 8'h42;
	localparam logic [7:0] OFS_TIMER      = 8'h79;

	// Reset values
	localparam logic [7:0] CFG_RST  = 8'h00;
	localparam logic [7:0] CRIT_RST = 8'h64;

	// Writable register file, index order
	localparam int NREGS = 12;
	localparam int IX_CFG = 0;      // Channel configs occupy 0..2
	localparam int IX_ACOUSTICS = 3;
	localparam int IX_CRIT = 4;     // Critical limits occupy 4..6
	localparam int IX_MASK_TWO = 7;
	localparam int IX_CFG_THREE = 8;
	localparam int IX_TLIMIT = 9;
	localparam int IX_CFG_FOUR = 10;
	localparam int IX_PWM_FREQ = 11;
	localparam logic [NREGS-1:0][7:0] REG_OFS = {OFS_PWM_FREQ, OFS_CFG_FOUR, OFS_TLIMIT,
		OFS_CFG_THREE, OFS_MASK_TWO, OFS_R2_CRIT, OFS_LOC_CRIT, OFS_R1_CRIT,
		OFS_ACOUSTICS, OFS_R2_CFG, OFS_LOC_CFG, OFS_R1_CFG};
	localparam logic [NREGS-1:0][7:0] REG_RST = {CFG_RST, CFG_RST, CFG_RST, CFG_RST,
		CFG_RST, CRIT_RST, CRIT_RST, CRIT_RST, CFG_RST, CFG_RST, CFG_RST, CFG_RST};

	// Field positions
	localparam int BIT_THERMAL_THROTTLE_PIN_OUT_EN = 3;  // Channel config
	localparam int BIT_SYNC         = 4;  // Acoustics control one
	localparam int BIT_LIMIT_FLAG   = 5;  // Status two and mask two
	localparam int BIT_TIMER_EN     = 1;  // Config three
	localparam int BIT_FULL_DUTY    = 2;  // Config three
	localparam logic [1:0] PINFN_SPEED   = 2'h0;
	localparam logic [1:0] PINFN_THERMAL = 2'h1;
	localparam logic [2:0] PWM_FREQ_HIGH = 3'h7;
	localparam logic [7:0] DIS_OFFSET64  = 8'h00; // -64 C in offset-64 code
	localparam logic [7:0] DIS_TWOS      = 8'h80; // -128 C in two's complement

	// Drive output numbers for speed input synchronisation
	localparam logic [1:0] DRIVE_ONE   = 2'h1;
	localparam logic [1:0] DRIVE_TWO   = 2'h2;
	localparam logic [1:0] DRIVE_THREE = 2'h3;

	// Temperatures: eight integer bits and two quarter-degree bits
	typedef struct packed {
		logic [2:0][9:0] reading; // 0 remote one, 1 local, 2 remote two
		logic [2:0]      done;    // One-cycle pulse per channel per monitoring cycle
	} temp_set_t;

	// Drive output each speed input is synchronised to
	typedef struct packed {
		logic [1:0] speed1;
		logic [1:0] speed2;
		logic [1:0] speed3;
		logic [1:0] speed4;
	} sync_map_t;
endpackage

/* File: src/pin_sync.sv */
// Three-stage input synchroniser that accepts a level once two stages agree
module pin_sync
	import thermal_throttle_pin_pkg::*;
(
	input  wire logic ref_clk,
	input  wire logic rst_b,
	input  wire logic pin_in,
	output logic      pin_level
);
	logic stage1_ff;
	logic stage2_ff;
	logic stage3_ff;
	logic level_ff;

	// First stage feeds only the second; level moves when the last two agree
	always_ff @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			stage1_ff <= 1'b1;
			stage2_ff <= 1'b1;
			stage3_ff <= 1'b1;
			level_ff  <= 1'b1;
		end
		else
		begin
			stage1_ff <= pin_in;
			stage2_ff <= stage1_ff;
			stage3_ff <= stage2_ff;
			if (stage2_ff == stage3_ff)
				level_ff <= stage3_ff;
		end
	end

	assign pin_level = level_ff;
endmodule // pin_sync

/* File: dv/cpu_throttle_model.sv */
// Processor side of the throttle line: its hot output and the shared open-drain wire
module cpu_throttle_model
(
	input  wire logic processor_hot_signal,
	input  wire logic dev_out,
	input  wire logic dev_oe,
	output logic      wire_level
);
	timeunit 1ns;
	timeprecision 1ns;

	// Pull-up wire: whichever party pulls low wins, released means high
	assign wire_level = !(processor_hot_signal || (dev_oe && !dev_out));
endmodule // cpu_throttle_model

/* File: dv/thermal_pin_limit_alert_and_tach_sync_tb_top.sv */
// Self-checking bench for the thermal pin timer, alert, pin drive and speed sync
`define CHK(n, e, g) check(n, 8'(e), 8'(g))
module thermal_pin_limit_alert_and_tach_sync_tb_top
	import thermal_throttle_pin_pkg::*;
();
	timeunit 1ns;
	timeprecision 1ns;
	logic        ref_clk = 1'b0;
	logic        rst_b = 1'b0;
	logic [7:0]  reg_addr = 8'h00;
	logic [7:0]  reg_wdata = 8'h00;
	logic        reg_wr = 1'b0;
	logic        reg_rd = 1'b0;
	logic [7:0]  reg_rdata;
	logic        pin_out, pin_oe, pin_wire, smbalert_b, full_duty, speed4;
	logic        cpu_hot = 1'b0;
	temp_set_t   temps = '0;
	logic        offset64_mode = 1'b0;
	logic        fans_running = 1'b0;
	logic        four_wire_fans = 1'b0;
	sync_map_t   tach_sync;
	logic        sync_needed, pwm_high;
	logic [2:0]  pwm_sel;
	int          err_count = 0;
	int          n_compared = 0;
	logic [31:0] seed = 32'd80065;
	logic [7:0]  exp_q[$];
	string       name_q[$];
	logic        rd_pend = 1'b0;

	// Short timer step keeps the saturation case within a few thousand cycles
	thermal_throttle_pin_timer_alert #(.STEP_CYCLES(8)) i_thermal_throttle_pin_timer_alert (.ref_clk(ref_clk), .rst_b(rst_b),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .thermal_throttle_pin_in(pin_wire),
		.thermal_throttle_pin_out(pin_out), .thermal_throttle_pin_oe(pin_oe),
		.smbalert_b(smbalert_b), .temps(temps), .offset64_mode(offset64_mode),
		.fans_running(fans_running), .four_wire_fans(four_wire_fans),
		.full_duty_override(full_duty), .fourth_speed_input(speed4), .tach_sync(tach_sync),
		.tach_sync_needed(sync_needed), .pwm_freq_sel(pwm_sel), .pwm_high_freq(pwm_high));
	cpu_throttle_model i_cpu_throttle_model (.processor_hot_signal(cpu_hot),
		.dev_out(pin_out), .dev_oe(pin_oe), .wire_level(pin_wire));

	always #50 ref_clk = ~ref_clk;

	function automatic logic [31:0] xorshift();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	task automatic check(input string n, input logic [7:0] e, input logic [7:0] g);
		n_compared++;
		if (g !== e)
		begin
			err_count++;
			$display("mismatch %s expected %h seen %h", n, e, g);
		end
	endtask

	task automatic conclude();
		$display("compared %0d mismatches %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
	endtask

	// Read notes its expectation; the monitor compares one cycle later
	task automatic rd(input logic [7:0] a, input logic [7:0] e, input string n);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		exp_q.push_back(e);
		name_q.push_back(n);
		@(posedge ref_clk);
		reg_rd <= 1'b0;
	endtask

	// Processor holds its hot line for n cycles, then lets the synchroniser drain
	task automatic hot(input int n);
		@(posedge ref_clk);
		cpu_hot <= 1'b1;
		repeat (n) @(posedge ref_clk);
		cpu_hot <= 1'b0;
		repeat (6) @(posedge ref_clk);
	endtask

	task automatic temp(input int ch, input logic [9:0] v);
		@(posedge ref_clk);
		temps.reading[ch] <= v;
		temps.done[ch] <= 1'b1;
		@(posedge ref_clk);
		temps.done[ch] <= 1'b0;
		repeat (3) @(posedge ref_clk);
	endtask

	// Read data is registered, so it is settled at the edge after the strobe
	always @(posedge ref_clk)
	begin
		if (rd_pend)
			`CHK(name_q.pop_front(), exp_q.pop_front(), reg_rdata);
		rd_pend <= reg_rd;
	end

	// Watchdog: the whole sequence needs well under this many cycles
	initial
	begin
		repeat (20000) @(posedge ref_clk);
		err_count++;
		conclude();
	end

	initial
	begin
		logic [7:0] d;
		repeat (6) @(posedge ref_clk);
		rst_b <= 1'b1;
		`CHK("alert idle", 1, smbalert_b);
		`CHK("sync reset", 8'h6f, tach_sync);
		for (int i = 0; i < NREGS; i++)
			rd(REG_OFS[i], REG_RST[i], "reset value");
		rd(8'h00, 8'h00, "unmapped");
		for (int i = 0; i < NREGS; i++)
		begin
			d = 8'(xorshift());
			wr(REG_OFS[i], d);
			rd(REG_OFS[i], d, "read back");
			wr(REG_OFS[i], REG_RST[i]);
		end
		wr(8'h79, 8'hff);
		rd(8'h79, 8'h00, "timer ro");
		wr(OFS_ACOUSTICS, 8'h10);
		repeat (2) @(posedge ref_clk);
		`CHK("sync on", 8'h7f, tach_sync);
		wr(OFS_ACOUSTICS, 8'h00);
		repeat (2) @(posedge ref_clk);
		`CHK("sync off", 8'h6f, tach_sync);
		four_wire_fans <= 1'b1;
		for (int f = 0; f < 8; f++)
		begin
			wr(OFS_PWM_FREQ, 8'(f));
			repeat (2) @(posedge ref_clk);
			`CHK("freq sel", f, pwm_sel);
			`CHK("high freq", f == 7, pwm_high);
			`CHK("sync need", f != 7, sync_needed);
		end
		four_wire_fans <= 1'b0;
		repeat (2) @(posedge ref_clk);
		`CHK("sync need 3w", 1, sync_needed);
		// Pin as speed input while the timer is still off
		cpu_hot <= 1'b1;
		repeat (6) @(posedge ref_clk);
		`CHK("speed4 pin", 0, speed4);
		// Pin routed to the timer but monitoring still off: nothing may count
		wr(OFS_CFG_FOUR, 8'h01);
		hot(1);
		rd(OFS_TIMER, 8'h00, "timer off");
		wr(OFS_CFG_THREE, 8'h02);
		// Two assertions of about 20 and 24 cycles sum to five steps
		hot(20);
		`CHK("speed4 gone", 1, speed4);
		`CHK("alert lim0", 0, smbalert_b);
		hot(24);
		rd(OFS_STATUS_TWO, 8'h20, "flag held");
		rd(OFS_TIMER, 8'h05, "timer sum");
		rd(OFS_STATUS_TWO, 8'h20, "flag lim0");
		rd(OFS_STATUS_TWO, 8'h00, "flag clear");
		repeat (3) @(posedge ref_clk);
		`CHK("alert clear", 1, smbalert_b);
		hot(2080);
		rd(OFS_TIMER, 8'hff, "timer sat");
		rd(OFS_TIMER, 8'h00, "timer clr");
		rd(OFS_STATUS_TWO, 8'h20, "flag sat");
		wr(OFS_TLIMIT, 8'h01);
		hot(10);
		`CHK("alert lim1 lo", 1, smbalert_b);
		hot(10);
		`CHK("alert lim1 hi", 0, smbalert_b);
		rd(OFS_TIMER, 8'h02, "timer two");
		rd(OFS_STATUS_TWO, 8'h20, "flag lim1");
		wr(OFS_TLIMIT, 8'h00);
		wr(OFS_MASK_TWO, 8'h20);
		hot(4);
		`CHK("alert masked", 1, smbalert_b);
		rd(OFS_TIMER, 8'h01, "timer one");
		rd(OFS_STATUS_TWO, 8'h20, "flag masked");
		wr(OFS_MASK_TWO, 8'h00);
		// Full duty only while running fans see the pin low
		wr(OFS_CFG_THREE, 8'h06);
		fans_running <= 1'b1;
		cpu_hot <= 1'b1;
		repeat (8) @(posedge ref_clk);
		`CHK("full duty", 1, full_duty);
		fans_running <= 1'b0;
		repeat (3) @(posedge ref_clk);
		`CHK("duty stopped", 0, full_duty);
		fans_running <= 1'b1;
		wr(OFS_CFG_THREE, 8'h02);
		repeat (3) @(posedge ref_clk);
		`CHK("duty bit off", 0, full_duty);
		hot(1);
		// Pin drive per channel at a limit of 0x40, one quarter degree above it and exactly at it
		for (int ch = 0; ch < 3; ch++)
		begin
			wr(8'(OFS_R1_CFG + ch), 8'h08);
			wr(8'(OFS_R1_CRIT + ch), 8'h40);
			temp(ch, 10'h101);
			`CHK("pin drive", 1, pin_oe);
			`CHK("pin wire", 0, pin_wire);
			temp(ch, 10'h100);
			`CHK("pin release", 0, pin_oe);
			temp(ch, 10'h101);
			wr(8'(OFS_R1_CFG + ch), 8'h00);
			repeat (3) @(posedge ref_clk);
			`CHK("chan off", 0, pin_oe);
			wr(8'(OFS_R1_CFG + ch), 8'h08);
			wr(8'(OFS_R1_CRIT + ch), 8'h80);
			temp(ch, 10'h1ff);
			`CHK("twos dis", 0, pin_oe);
			offset64_mode <= 1'b1;
			wr(8'(OFS_R1_CRIT + ch), 8'h00);
			temp(ch, 10'h3ff);
			`CHK("off64 dis", 0, pin_oe);
			offset64_mode <= 1'b0;
			wr(8'(OFS_R1_CFG + ch), 8'h00);
		end
		repeat (3) @(posedge ref_clk);
		conclude();
	end
endmodule // thermal_pin_limit_alert_and_tach_sync_tb_top
